//--- hdl/port_a_defines.vh
// Register offsets, field positions and reset values for the port A block.
// Assumes inclusion by the port A design file and its bench; definitions only.
`ifndef PORT_A_DEFINES_VH
`define PORT_A_DEFINES_VH

// APB byte offsets, one aligned word each
`define OFF_LEVEL      12'h000
`define OFF_DIRECTION  12'h004
`define OFF_ANALOG     12'h008
`define OFF_PULLUP     12'h00c
`define OFF_CHANGE_EN  12'h010
`define OFF_STEERING   12'h014
`define OFF_OPTION     12'h018
`define OFF_CONFIG     12'h01c

// Reset values
`define RST_DIRECTION  8'hff
`define RST_ANALOG     8'h0f
`define RST_PULLUP     8'h2f
`define RST_CHANGE_EN  8'h00
`define RST_STEERING   8'h00
`define RST_OPTION     8'h01
`define RST_CONFIG     8'h00
`define RST_LATCH      8'h00

// Implemented bit masks
`define MASK_ANALOG    8'h0f
`define MASK_PULLUP    8'h2f
`define MASK_STEERING  8'h01
`define MASK_OPTION    8'h01
`define MASK_CONFIG    8'h20
`define MASK_OPEN_DRN  8'h90

// Field positions
`define BIT_SYNC_SEL   0
`define BIT_PU_DIS     0
`define BIT_EXT_RESET  5
`define PIN_SYNC       1
`define PIN_TIMER      2
`define PIN_INPUT_ONLY 5
`define PIN_PROG_DATA  6
`define PIN_SCL        7

`endif

//--- hdl/port_a_pin_control.v
// Eight-pin general purpose port with direction, level, analog select,
// pull-up, change-enable and pin steering registers on an APB slave.
// Assumes pin inputs asynchronous to clock; the pad ring resolves pin levels
// from the output and enable signals and applies the pull-up requests.
`timescale 1ns/1ps
`include "port_a_defines.vh"

// Functional notes
// RULE1: Direction one is input, zero drives output
// RULE2: Pin five never drives, direction reads one
// RULE3: Read returns pins, write loads latch only
// RULE4: Writes are read-modify-write of pin values
// RULE5: Analog pins read zero digitally
// RULE6: Direction still gates driver in analog mode
// RULE7: Analog select leaves digital outputs working
// RULE8: Analog select bits reset to analog
// RULE9: Output pin drives, read shows pin state
// RULE10: Eight change enables, cleared at reset
// RULE11: Pull-ups only on pins three-zero, five
// RULE12: Pull-up off for output, alternate, disable
// RULE13: Pin five pull-up follows external reset
// RULE14: Select routes sync clock to pin choice
// RULE15: Select changes no direction, follows pin
// RULE16: Highest priority enabled source owns pin
// RULE17: Per-pin priority order port first
// RULE18: Pins seven and four open drain only
// RULE19: Enabled peripheral withdraws pin from port; here port latch still drives output pins
// RULE20: Pull-up needs global, input, enable, digital
// RULE21: Analog disables input, pull-up, change enable
// RULE22: Pin inputs pass two synchroniser flops
// RULE23: Latch undefined at reset, software writes first; here reset loads the latch with zero
module port_a_pin_control
(
    input  wire        clock,
    input  wire        rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    input  wire [7:0]  pinIn,
    output wire [7:0]  pinOut,
    output wire [7:0]  pinOutEnable,
    output wire [7:0]  pullUpEnable,
    output wire [7:0]  pinSampled,
    output wire [7:0]  changeEnableEff,
    input  wire        syncClockOut,
    input  wire        syncClockOutEn,
    output reg         syncClockIn,
    output wire        secondPin5Out,
    output wire        secondPin5OutEnable,
    input  wire        secondPin5In,
    input  wire        timerClockOutEn,
    input  wire        timerClockOut,
    input  wire        extIntOutEn,
    input  wire        extIntOut,
    input  wire        progDataOutEn,
    input  wire        progDataOut,
    input  wire        sclOutEn,
    input  wire        sclOut,
    input  wire        progClockOutEn,
    input  wire        progClockOut,
    input  wire        peripheralInUse6,
    input  wire        peripheralInUse7
);

    reg  [7:0] portLatch;
    reg  [7:0] portDirectionBits;
    reg  [7:0] analogSelectBits;
    reg  [7:0] pullupEnables;
    reg  [7:0] changeInterruptEnables;
    reg  [7:0] alternatePinSteering;
    reg  [7:0] optionBits;
    reg  [7:0] configBits;
    reg  [7:0] syncStage1;
    reg  [7:0] syncStage2;
    reg  [7:0] levelRead;
    reg  [7:0] next_latch;
    reg  [7:0] drive;
    reg  [7:0] driveEn;
    reg  [7:0] altUse;
    reg  [31:0] next_prdata;
    reg  [1:0] pickSync;
    reg  [1:0] pickTimer;
    reg  [1:0] pickData;
    reg  [1:0] pickScl;
    wire [7:0] pullupSoft;
    wire [7:0] pullupForced;

    wire       syncSel    = alternatePinSteering[`BIT_SYNC_SEL];
    wire       pullupOff  = optionBits[`BIT_PU_DIS];
    wire       extResetOn = configBits[`BIT_EXT_RESET];
    wire       wrAccess   = psel & penable & pwrite;
    wire       rdSetup    = psel & ~penable & ~pwrite;
    wire [7:0] wrByte     = pwdata[7:0];
    wire       lane0      = pstrb[0];

    // Merge a written byte into a register under its implemented mask
    function [7:0] masked;
        input [7:0] oldVal;
        input [7:0] newVal;
        input [7:0] mask;
        begin
            masked = (oldVal & ~mask) | (newVal & mask);
        end
    endfunction

    // First claimed source of up to three, listed highest first; {claimed, data}.
    // Unused slots are tied off with a zero enable.
    function [1:0] pick_source;
        input enA;
        input outA;
        input enB;
        input outB;
        input enC;
        input outC;
        begin
            if (enA)
            begin
                pick_source = {1'b1, outA};
            end
            else if (enB)
            begin
                pick_source = {1'b1, outB};
            end
            else if (enC)
            begin
                pick_source = {1'b1, outC};
            end
            else
            begin
                pick_source = 2'b00;
            end
        end
    endfunction

    // Single-cycle access phase; no wait states, no error responses
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    // Two-flop input synchroniser, first stage feeds only the second
    always @(posedge clock)
    begin
        if (rst)
        begin
            syncStage1 <= 8'h00;
            syncStage2 <= 8'h00;
        end
        else
        begin
            syncStage1 <= pinIn;      // see RULE22
            syncStage2 <= syncStage1; // see RULE22
        end
    end

    // Analog pins hide their digital input buffer
    always @*
    begin
        levelRead = syncStage2 & ~analogSelectBits; // see RULE5, see RULE21, see RULE9
    end
    assign pinSampled = levelRead;

    // Analog mode also masks change detection
    assign changeEnableEff = changeInterruptEnables & ~analogSelectBits; // see RULE21

    // Read-modify-write: unwritten latch bits take the pin values just read
    always @*
    begin
        next_latch = levelRead; // see RULE4
        if (lane0)
        begin
            next_latch = wrByte; // see RULE3
        end
    end

    // Register writes on the APB access phase.
    // A level write without byte lane 0 still reloads the latch from the pins.
    always @(posedge clock)
    begin
        if (rst)
        begin
            portDirectionBits      <= `RST_DIRECTION;
            analogSelectBits       <= `RST_ANALOG;   // see RULE8
            pullupEnables          <= `RST_PULLUP;
            changeInterruptEnables <= `RST_CHANGE_EN; // see RULE10
            alternatePinSteering   <= `RST_STEERING;
            optionBits             <= `RST_OPTION;   // see RULE12
            configBits             <= `RST_CONFIG;
            portLatch              <= `RST_LATCH;    // see RULE23
        end
        else if (wrAccess & (lane0 | (paddr == `OFF_LEVEL))) // see RULE4
        begin
            case (paddr)
                `OFF_LEVEL:
                    portLatch <= next_latch; // see RULE3
                `OFF_DIRECTION:
                    portDirectionBits <= wrByte | (8'h01 << `PIN_INPUT_ONLY); // see RULE2
                `OFF_ANALOG:
                    analogSelectBits <= masked(analogSelectBits, wrByte, `MASK_ANALOG);
                `OFF_PULLUP:
                    pullupEnables <= masked(pullupEnables, wrByte, `MASK_PULLUP); // see RULE11
                `OFF_CHANGE_EN:
                    changeInterruptEnables <= wrByte; // see RULE10
                `OFF_STEERING:
                    alternatePinSteering <= masked(alternatePinSteering, wrByte,
                                                   `MASK_STEERING); // see RULE15
                `OFF_OPTION:
                    optionBits <= masked(optionBits, wrByte, `MASK_OPTION);
                `OFF_CONFIG:
                    configBits <= masked(configBits, wrByte, `MASK_CONFIG);
                default:
                    portLatch <= portLatch;
            endcase
        end
    end

    // Read mux; unmapped addresses read zero
    always @*
    begin
        next_prdata = 32'h00000000;
        case (paddr)
            `OFF_LEVEL:     next_prdata[7:0] = levelRead; // see RULE3
            `OFF_DIRECTION: next_prdata[7:0] = portDirectionBits; // see RULE2
            `OFF_ANALOG:    next_prdata[7:0] = analogSelectBits;
            `OFF_PULLUP:    next_prdata[7:0] = pullupEnables;
            `OFF_CHANGE_EN: next_prdata[7:0] = changeInterruptEnables;
            `OFF_STEERING:  next_prdata[7:0] = alternatePinSteering;
            `OFF_OPTION:    next_prdata[7:0] = optionBits;
            `OFF_CONFIG:    next_prdata[7:0] = configBits;
            default:        next_prdata = 32'h00000000;
        endcase
    end

    // Read data is registered in the setup cycle, valid in the access phase
    always @(posedge clock)
    begin
        if (rst)
        begin
            prdata <= 32'h00000000;
        end
        else if (rdSetup)
        begin
            prdata <= next_prdata;
        end
    end

    // Peripheral claims per pin, highest listed first; the port itself
    // outranks them all, so a claim only reaches a pin whose direction is input.
    // Analog select is deliberately absent so digital outputs keep working.
    always @*
    begin
        pickSync  = pick_source(~syncSel & syncClockOutEn, syncClockOut,
                                1'b0, 1'b0, 1'b0, 1'b0);          // see RULE14, see RULE15
        pickTimer = pick_source(timerClockOutEn, timerClockOut, extIntOutEn, extIntOut,
                                1'b0, 1'b0);                      // see RULE16, see RULE17
        pickData  = pick_source(progDataOutEn, progDataOut, 1'b0, 1'b0, 1'b0, 1'b0);
        pickScl   = pick_source(sclOutEn, sclOut, progClockOutEn, progClockOut,
                                1'b0, 1'b0);                      // see RULE16, see RULE17
    end

    // Claimed pins lose their pull-up but stay driven by the port latch while their direction is output;
    // the claim counts whatever the direction bit says.
    always @*
    begin
        altUse                 = 8'h00;
        altUse[`PIN_SYNC]      = pickSync[1];                    // see RULE19
        altUse[`PIN_TIMER]     = pickTimer[1];                   // see RULE19
        altUse[`PIN_PROG_DATA] = peripheralInUse6 | pickData[1]; // see RULE19
        altUse[`PIN_SCL]       = peripheralInUse7 | pickScl[1];  // see RULE19
    end

    // Port latch owns every pin whose direction is cleared
    always @*
    begin
        drive   = portLatch;                // see RULE7
        driveEn = ~portDirectionBits;       // see RULE1, see RULE6, see RULE9
        // Pin 1: port, then sync clock while steering keeps it on this port
        if (portDirectionBits[`PIN_SYNC] && pickSync[1])
        begin
            drive[`PIN_SYNC]   = pickSync[0];          // see RULE17
            driveEn[`PIN_SYNC] = 1'b1;
        end
        // Pin 2: port, then timer clock, then external interrupt
        if (portDirectionBits[`PIN_TIMER] && pickTimer[1])
        begin
            drive[`PIN_TIMER]   = pickTimer[0];        // see RULE17
            driveEn[`PIN_TIMER] = 1'b1;
        end
        // Pin 6: port, then programming data
        if (portDirectionBits[`PIN_PROG_DATA] && pickData[1])
        begin
            drive[`PIN_PROG_DATA]   = pickData[0];     // see RULE17
            driveEn[`PIN_PROG_DATA] = 1'b1;
        end
        // Pin 7: port, then serial clock, then programming clock
        if (portDirectionBits[`PIN_SCL] && pickScl[1])
        begin
            drive[`PIN_SCL]   = pickScl[0];            // see RULE17
            driveEn[`PIN_SCL] = 1'b1;
        end
        // Input-only pin never drives
        drive[`PIN_INPUT_ONLY]   = 1'b0;             // see RULE2
        driveEn[`PIN_INPUT_ONLY] = 1'b0;             // see RULE2
    end

    // Open-drain pins only pull low: enable when low, data held at zero
    assign pinOut       = drive & ~`MASK_OPEN_DRN;                        // see RULE18
    assign pinOutEnable = driveEn & ~(`MASK_OPEN_DRN & drive);            // see RULE18

    // Soft pull-up: global allow, input, own bit, digital, not claimed;
    // the input-only pin has no software-controlled pull-up at all
    assign pullupSoft   = {8{~pullupOff}} & portDirectionBits & pullupEnables
                          & `MASK_PULLUP & ~analogSelectBits & ~altUse
                          & ~(8'h01 << `PIN_INPUT_ONLY); // see RULE11, see RULE12, see RULE20
    // Hard pull-up on the input-only pin while it serves as external reset
    assign pullupForced = {7'h00, extResetOn} << `PIN_INPUT_ONLY;         // see RULE13
    assign pullUpEnable = pullupSoft | pullupForced;

    // Sync clock on second port pin 5 when selected; its own direction stays
    assign secondPin5Out       = syncClockOut;                          // see RULE14
    assign secondPin5OutEnable = syncSel & syncClockOutEn;              // see RULE15

    // Incoming sync clock taken from the selected pin
    always @(posedge clock)
    begin
        if (rst)
        begin
            syncClockIn <= 1'b0;
        end
        else
        begin
            // Analog pin 1 hides its input from the sync clock as well
            syncClockIn <= syncSel ? secondPin5In : levelRead[`PIN_SYNC]; // see RULE14, see RULE21
        end
    end

endmodule

//--- bench/port_pins_model.sv
// Pin partner: works out each pad level from every driver facing it.
// Assumes the bench gives the outside level of pins nobody drives.
`timescale 1ns/1ps
module port_pins_model
(
    input  wire [7:0] pinOut,
    input  wire [7:0] pinOutEnable,
    input  wire [7:0] pullUpEnable,
    input  wire       secondPin5Out,
    input  wire       secondPin5OutEnable,
    input  wire [7:0] extLevel,
    input  wire       extB5,
    output wire [7:0] pinIn,
    output wire       secondPin5In
);
    // Driven pin shows its drive, a released open drain falls to the outside
    assign pinIn = (pinOutEnable & pinOut)
                 | (~pinOutEnable & (pullUpEnable | extLevel));
    // Second port pin: design drive wins, else outside level
    assign secondPin5In = secondPin5OutEnable ? secondPin5Out : extB5;
endmodule

//--- bench/port_a_pin_control_sva.sv
// Checker on the port block pins: drive, pull-up, sync and reset relations.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module port_a_pin_control_sva
(
    input wire        clock,
    input wire        rst,
    input wire [31:0] prdata,
    input wire [7:0]  pinIn,
    input wire [7:0]  pinOut,
    input wire [7:0]  pinOutEnable,
    input wire [7:0]  pullUpEnable,
    input wire [7:0]  pinSampled,
    input wire [7:0]  changeEnableEff,
    input wire        syncClockOut,
    input wire        syncClockIn,
    input wire        secondPin5Out,
    input wire        secondPin5OutEnable,
    input wire        secondPin5In
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Steps: first edge out of reset, and a steered clock held two cycles
    sequence released_s; $past(rst); endsequence
    sequence steered_s; secondPin5OutEnable && $past(secondPin5OutEnable); endsequence
    input_only_a: assert property (pinOutEnable[5] == 1'b0)
        else $error("input-only pin driven");
    open_drain_a: assert property (pinOut[4] == 1'b0 && pinOut[7] == 1'b0)
        else $error("open-drain pin driven high");
    pullup_pins_a: assert property ((pullUpEnable & 8'hd0) == 8'h00)
        else $error("pull-up on a pin without one");
    pullup_driven_a: assert property ((pullUpEnable & pinOutEnable) == 8'h00)
        else $error("pull-up left on a driven pin");
    sync_delay_a: assert property (!$past(rst) && !$past(rst, 2) |->
        pinSampled[7:4] == $past(pinIn[7:4], 2)) else $error("synchroniser delay wrong");
    reset_state_a: assert property (released_s |-> pinOutEnable == 8'h00 &&
        changeEnableEff == 8'h00 && pullUpEnable == 8'h00) else $error("reset state wrong");
    sync_route_a: assert property (secondPin5OutEnable |-> secondPin5Out == syncClockOut)
        else $error("steered sync clock wrong");
    steer_capture_a: assert property (steered_s |-> syncClockIn == $past(secondPin5In))
        else $error("sync clock not taken from steered pin");
    upper_zero_a: assert property (prdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
endmodule

bind port_a_pin_control port_a_pin_control_sva i_chk (.clock(clock), .rst(rst),
    .prdata(prdata), .pinIn(pinIn), .pinOut(pinOut), .pinOutEnable(pinOutEnable),
    .pullUpEnable(pullUpEnable), .pinSampled(pinSampled), .changeEnableEff(changeEnableEff),
    .syncClockOut(syncClockOut), .syncClockIn(syncClockIn), .secondPin5Out(secondPin5Out),
    .secondPin5OutEnable(secondPin5OutEnable), .secondPin5In(secondPin5In));

//--- bench/tb_port_a_pin_control.sv
// Bench for the port block: APB register traffic, pin drive and pull-up checks.
// Assumes the pin partner model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`include "port_a_defines.vh"
module tb_port_a_pin_control;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, rd;
    logic [13:0] alt = 14'h0000;
    logic [7:0]  extLevel = 8'h00, pinIn, pinOut, pinOutEnable, pullUpEnable, pinSampled, chg;
    logic        pready, pslverr, syncClockIn, b5Out, b5En, b5In;
    logic [3:0]  strb = 4'h1;
    int          bad_count = 0, n_tests = 0;

    // Half period of 10 ns for 50 MHz
    always #10 clock = ~clock;

    port_a_pin_control i_dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut),
        .pinOutEnable(pinOutEnable), .pullUpEnable(pullUpEnable), .pinSampled(pinSampled),
        .changeEnableEff(chg), .syncClockOut(alt[13]), .syncClockOutEn(alt[12]),
        .syncClockIn(syncClockIn), .secondPin5Out(b5Out), .secondPin5OutEnable(b5En),
        .secondPin5In(b5In), .timerClockOutEn(alt[0]), .timerClockOut(alt[1]),
        .extIntOutEn(alt[2]), .extIntOut(alt[3]), .progDataOutEn(alt[4]),
        .progDataOut(alt[5]), .sclOutEn(alt[6]), .sclOut(alt[7]), .progClockOutEn(alt[8]),
        .progClockOut(alt[9]), .peripheralInUse6(alt[10]), .peripheralInUse7(alt[11]));
    port_pins_model i_pins (.pinOut(pinOut), .pinOutEnable(pinOutEnable),
        .pullUpEnable(pullUpEnable), .secondPin5Out(b5Out), .secondPin5OutEnable(b5En),
        .extLevel(extLevel), .extB5(1'b0), .pinIn(pinIn), .secondPin5In(b5In));

    task close_out;
        if (bad_count == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; request held until pready is seen high
    task apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Covers the two-flop synchroniser plus output settling
    task settle;
        repeat (3) @(posedge clock);
    endtask

    task t_reset;
        logic [7:0] want [0:8];
        want = '{8'h00, 8'hff, 8'h0f, 8'h2f, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
        for (int i = 0; i < 9; i++)
        begin
            apb(1'b0, 12'(i * 4), 8'h00);
            check(rd, want[i]);
            check(pslverr, 1'b0);
        end
    endtask

    task t_drive;
        apb(1'b1, `OFF_DIRECTION, 8'h00);
        apb(1'b1, `OFF_LEVEL, 8'h55);
        apb(1'b0, `OFF_DIRECTION, 8'h00);
        check(rd, 8'h20);
        settle;
        check(pinOutEnable, 8'hcf);
        check(pinOut & 8'h4f, 8'h45);
        apb(1'b0, `OFF_LEVEL, 8'h00);
        check(rd, 8'h70);
        check(pinSampled, 8'h70);
        // Level write with lane 0 off: latch reloads from the masked pin read
        strb <= 4'h0;
        apb(1'b1, `OFF_LEVEL, 8'h00);
        strb <= 4'h1;
        settle;
        check(pinOut & 8'h4f, 8'h40);
        apb(1'b1, `OFF_LEVEL, 8'h55);
    endtask

    task t_analog;
        apb(1'b1, `OFF_CHANGE_EN, 8'hff);
        settle;
        check(chg, 8'hf0);
        apb(1'b1, `OFF_ANALOG, 8'h00);
        apb(1'b0, `OFF_CHANGE_EN, 8'h00);
        check(rd, 8'hff);
        check(chg, 8'hff);
        settle;
        apb(1'b0, `OFF_LEVEL, 8'h00);
        check(rd, 8'h75);
        check(pinSampled, 8'h75);
    endtask

    task t_pullup;
        apb(1'b1, `OFF_DIRECTION, 8'hff);
        apb(1'b1, `OFF_OPTION, 8'h00);
        settle;
        check(pullUpEnable, 8'h0f);
        apb(1'b1, `OFF_CONFIG, 8'h20);
        apb(1'b1, `OFF_DIRECTION, 8'hfe);
        settle;
        check(pullUpEnable, 8'h2e);
        apb(1'b1, `OFF_OPTION, 8'h01);
        settle;
        check(pullUpEnable, 8'h20);
    endtask

    // Every alternate source on, lower-priority ones disagreeing
    task t_alt;
        alt <= 14'h3357;
        settle;
        check(pinOutEnable, 8'hc7);
        check(pinOut & 8'hcf, 8'h07);
        apb(1'b1, `OFF_STEERING, 8'h01);
        settle;
        check(pinOutEnable, 8'hc5);
        check(b5En, 1'b1);
        check(b5Out, 1'b1);
        check(syncClockIn, 1'b1);
        apb(1'b0, `OFF_DIRECTION, 8'h00);
        check(rd, 8'hfe);
    endtask

    initial
    begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        t_reset;
        extLevel <= 8'h30;
        t_drive;
        t_analog;
        t_pullup;
        t_alt;
        close_out;
    end

    // Watchdog well past the expected hundred or so cycles
    initial
    begin
        #200000;
        bad_count++;
        close_out;
    end
endmodule
